/* dwc_top.sv */
// debug status readback, watchpoint coupling and comms channel
`include "dwc_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: interrupt gate low while halt acknowledged or interrupt block bit set.
// RULE2: five-bit status register reachable over the scan access port.
// RULE3: scan write bit high writes status, low reads it back; here a status write is ignored.
// RULE4: status bits 1 and 0 show synchronised halt request and acknowledge.
// RULE5: status bit 2 shows interrupt gate, built from synchronised acknowledge.
// RULE6: status bit 3 shows memory request, synchronised to the test clock.
// RULE7: status bit 4 shows the compressed instruction state flag.
// RULE8: with chain selected, watchpoint 0 triggers only after watchpoint 1 matched.
// RULE9: a field matches when each bit equals value or is masked.
// RULE10: watchpoint 1 address match loads its data match into the link latch.
// RULE11: span check is watchpoint 1 address and data match, feeding watchpoint 0.
// RULE12: disabled watchpoint still drives span check but raises no breakpoint.
// RULE13: channel answers as debug coprocessor 14 via register transfers.
// RULE14: channel has 32-bit inbound, 32-bit outbound and handshake registers.
// RULE15: handshake is read-only: version in 31:28, outbound bit 1, inbound bit 0.
// RULE16: processor write of outbound data sets the outbound pending flag.
// RULE17: processor writes outbound data only when outbound pending is clear.
// RULE18: debugger scan read of outbound data clears outbound pending.
// RULE19: debugger scan write of inbound data sets inbound pending.
// RULE20: debugger writes inbound data only when inbound pending is clear.
// RULE21: processor load of inbound data clears inbound pending.
// RULE22: each side sees both pending flags synchronised to its own clock.
// RULE23: decode: op 0 C0,C0 read handshake; C1,C0 write out; C1,C0 read in.
// RULE24: both pending flags are clear after reset.
module dwc_top #(
    parameter int SYNC = `DWC_SYNC
) (
    // processor clock and reset
    input  wire logic                mclk,
    input  wire logic                rstn,
    // test clock
    input  wire logic                tck,
    // core debug signals
    input  wire logic                halt_request,
    input  wire logic                halt_acknowledge,
    input  wire logic                interrupt_block_bit,
    input  wire logic                core_memory_request_n,
    input  wire logic                compressed_state_flag,
    output logic                     core_interrupt_gate,
    // watchpoints
    input  wire dwc_pkg::dwc_wp_cfg_t wp_cfg [2],
    input  wire dwc_pkg::dwc_bus_t   bus,
    output logic                     breakpoint,
    output logic                     link_trigger_out,
    output logic                     span_check_out,
    // coprocessor transfers
    input  wire dwc_pkg::dwc_cp_req_t cp_req,
    output logic                     cp_accept,
    output logic [31:0]              cp_rdata,
    // scan access
    input  wire logic                scan_strobe,
    input  wire dwc_pkg::dwc_sel_t   scan_sel,
    input  wire logic                scan_write,
    input  wire logic [31:0]         scan_wdata,
    output logic [31:0]              scan_rdata
);

    // depth below two gives no metastability margin
    if (SYNC < 2) begin : g_sync_chk
        $error("dwc_top: SYNC must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // bitwise compare, masked bits always match
    function automatic logic dwc_match(input logic [36:0] v,
                                       input logic [36:0] o,
                                       input logic [36:0] m);
        dwc_match = &(~(v ^ o) | m); // [RULE9]
    endfunction : dwc_match

    // coprocessor transfer decode
    function automatic dwc_pkg::dwc_op_t dwc_decode(input dwc_pkg::dwc_cp_req_t r);
        dwc_decode = dwc_pkg::DWC_OP_NONE;
        if (r.valid && r.num == `DWC_CP_NUM && r.opc == `DWC_CP_OPC // [RULE13]
            && r.crm == `DWC_CRM) begin
            if (!r.to_cop && r.crn == `DWC_CRN_HS) begin
                dwc_decode = dwc_pkg::DWC_OP_RD_HS; // [RULE23]
            end else if (r.to_cop && r.crn == `DWC_CRN_DATA) begin
                dwc_decode = dwc_pkg::DWC_OP_WR_OUT; // [RULE23]
            end else if (!r.to_cop && r.crn == `DWC_CRN_DATA) begin
                dwc_decode = dwc_pkg::DWC_OP_RD_IN; // [RULE23]
            end
        end
    endfunction : dwc_decode

    // handshake word from one side's view of the flags
    function automatic logic [31:0] dwc_hs(input logic outp, input logic inp);
        dwc_hs = '0;
        dwc_hs[`DWC_HS_VER_HI:`DWC_HS_VER_LO] = `DWC_HS_VER; // arbitrary code [RULE15]
        dwc_hs[`DWC_HS_OUT] = outp;
        dwc_hs[`DWC_HS_IN]  = inp;
    endfunction : dwc_hs

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [SYNC-1:0][2:0] ms_q;       // mclk synchroniser chain
    logic [SYNC-1:0][5:0] ts_q;       // tck synchroniser chain
    logic                 blk_m;
    logic                 in_set_m;
    logic                 out_clr_m;
    logic                 req_t;
    logic                 ack_t;
    logic                 mreq_t;
    logic                 cst_t;
    logic                 out_set_t;
    logic                 in_clr_t;
    logic                 gate_q;
    logic                 out_set_tgl_q;  // mclk side toggles
    logic                 in_clr_tgl_q;
    logic                 in_set_tgl_q;   // tck side toggles
    logic                 out_clr_tgl_q;
    logic                 out_pend_m;
    logic                 in_pend_m;
    logic                 out_pend_t;
    logic                 in_pend_t;
    logic [31:0]          out_data_q;
    logic [31:0]          in_data_q;
    logic [31:0]          cp_rdata_q;
    logic [31:0]          scan_rdata_q;
    logic [`DWC_ST_W-1:0] status;
    dwc_pkg::dwc_op_t     op;
    logic [1:0]           a_m;
    logic [1:0]           d_m;
    logic [1:0]           chain_in;
    logic [1:0]           range_in;
    logic [1:0]           hit;
    logic                 span1;
    logic                 link_q;
    logic                 span_q;
    logic                 bkpt_q;

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain: synchronisers and interrupt gate

    // only the last stage is read anywhere
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ms_q <= '0;
        end else begin
            ms_q[0] <= {in_set_tgl_q, out_clr_tgl_q, interrupt_block_bit};
            for (int i = 1; i < SYNC; i++) begin
                ms_q[i] <= ms_q[i-1];
            end
        end
    end

    assign blk_m     = ms_q[SYNC-1][0];
    assign out_clr_m = ms_q[SYNC-1][1];
    assign in_set_m  = ms_q[SYNC-1][2];

    // acknowledge is core-side, block bit comes over from tck
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gate_q <= 1'b1;
        end else begin
            gate_q <= !(halt_acknowledge || blk_m); // [RULE1]
        end
    end

    assign core_interrupt_gate = gate_q;

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain: comms channel, processor side

    // flags are xor of two toggles; each toggle has one owner [RULE22]
    assign out_pend_m = out_set_tgl_q ^ out_clr_m;
    assign in_pend_m  = in_set_m ^ in_clr_tgl_q;
    assign op         = dwc_decode(cp_req);
    assign cp_accept  = (op != dwc_pkg::DWC_OP_NONE);

    // outbound write; a write while pending is dropped, not overwritten
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            out_set_tgl_q <= 1'b0; // [RULE24]
            out_data_q    <= '0;
        end else if (op == dwc_pkg::DWC_OP_WR_OUT && !out_pend_m) begin // [RULE17]
            out_data_q    <= cp_req.wdata; // [RULE14]
            out_set_tgl_q <= !out_set_tgl_q; // [RULE16]
        end
    end

    // inbound load collects the word and frees the slot
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_clr_tgl_q <= 1'b0; // [RULE24]
        end else if (op == dwc_pkg::DWC_OP_RD_IN && in_pend_m) begin
            in_clr_tgl_q <= !in_clr_tgl_q; // [RULE21]
        end
    end

    // read data; inbound word is stable while its flag is seen set
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cp_rdata_q <= '0;
        end else begin
            case (op)
                dwc_pkg::DWC_OP_RD_HS: cp_rdata_q <= dwc_hs(out_pend_m, in_pend_m);
                dwc_pkg::DWC_OP_RD_IN: cp_rdata_q <= in_pend_m ? in_data_q : '0;
                default:               cp_rdata_q <= cp_rdata_q;
            endcase
        end
    end

    assign cp_rdata = cp_rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain: watchpoint comparators

    // watchpoint 1 has nothing upstream
    assign chain_in = {1'b0, link_q}; // [RULE8]
    assign range_in = {1'b0, span1};  // [RULE11]

    generate
        for (genvar g = 0; g < 2; g++) begin : g_wp
            logic [7:0] c;
            assign c = {range_in[g], chain_in[g], bus.ctrl};
            assign a_m[g] = dwc_match({wp_cfg[g].av, wp_cfg[g].cv[4:0]},
                                      {bus.addr, c[4:0]},
                                      {wp_cfg[g].am, wp_cfg[g].cm[4:0]}); // [RULE9]
            assign d_m[g] = dwc_match({2'b00, wp_cfg[g].dv, wp_cfg[g].cv[7:5]},
                                      {2'b00, bus.data, c[7:5]},
                                      {2'b00, wp_cfg[g].dm, wp_cfg[g].cm[7:5]}); // [RULE9]
            assign hit[g] = a_m[g] && d_m[g] && wp_cfg[g].cv[`DWC_C_EN]; // [RULE12]
        end
    endgenerate

    // span needs no enable, so a disabled unit can still bound a range
    assign span1 = a_m[1] && d_m[1]; // [RULE11] [RULE12]

    // link latch opens on address match only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link_q <= 1'b0;
        end else if (a_m[1]) begin
            link_q <= d_m[1]; // [RULE10]
        end
    end

    // registered breakpoint and span outputs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            span_q <= 1'b0;
            bkpt_q <= 1'b0;
        end else begin
            span_q <= span1; // [RULE11]
            bkpt_q <= |hit;
        end
    end

    assign link_trigger_out = link_q;
    assign span_check_out   = span_q;
    assign breakpoint       = bkpt_q;

    ////////////////////////////////////////////////////////////////////////////
    // tck domain: synchronisers and status

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            ts_q <= '0;
        end else begin
            ts_q[0] <= {in_clr_tgl_q, out_set_tgl_q, compressed_state_flag,
                        core_memory_request_n, halt_acknowledge, halt_request};
            for (int i = 1; i < SYNC; i++) begin
                ts_q[i] <= ts_q[i-1];
            end
        end
    end

    assign req_t     = ts_q[SYNC-1][0];
    assign ack_t     = ts_q[SYNC-1][1]; // [RULE5]
    assign mreq_t    = ts_q[SYNC-1][2]; // [RULE6]
    assign cst_t     = ts_q[SYNC-1][3];
    assign out_set_t = ts_q[SYNC-1][4];
    assign in_clr_t  = ts_q[SYNC-1][5];

    // status fields are live views, so writes leave nothing to hold
    always_comb begin
        status                = '0;
        status[`DWC_ST_REQ]   = req_t; // [RULE4]
        status[`DWC_ST_ACK]   = ack_t; // [RULE4]
        status[`DWC_ST_GATE]  = !(ack_t || interrupt_block_bit); // [RULE5]
        status[`DWC_ST_MREQ]  = mreq_t; // [RULE6]
        status[`DWC_ST_CSTATE] = cst_t; // [RULE7]
    end

    ////////////////////////////////////////////////////////////////////////////
    // tck domain: comms channel, debugger side

    assign out_pend_t = out_set_t ^ out_clr_tgl_q; // [RULE22]
    assign in_pend_t  = in_set_tgl_q ^ in_clr_t;   // [RULE22]

    // inbound write only into an empty slot
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            in_set_tgl_q <= 1'b0; // [RULE24]
            in_data_q    <= '0;
        end else if (scan_strobe && scan_write && scan_sel == dwc_pkg::DWC_SEL_IN
                     && !in_pend_t) begin // [RULE20]
            in_data_q    <= scan_wdata; // [RULE14]
            in_set_tgl_q <= !in_set_tgl_q; // [RULE19]
        end
    end

    // outbound read frees the slot for the processor
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            out_clr_tgl_q <= 1'b0; // [RULE24]
        end else if (scan_strobe && !scan_write && scan_sel == dwc_pkg::DWC_SEL_OUT
                     && out_pend_t) begin
            out_clr_tgl_q <= !out_clr_tgl_q; // [RULE18]
        end
    end

    // scan read data; outbound word only sampled while known stable
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            scan_rdata_q <= '0;
        end else if (scan_strobe && !scan_write) begin // [RULE3]
            case (scan_sel)
                dwc_pkg::DWC_SEL_STATUS: scan_rdata_q <= {27'h0, status}; // [RULE2]
                dwc_pkg::DWC_SEL_HS:     scan_rdata_q <= dwc_hs(out_pend_t, in_pend_t);
                dwc_pkg::DWC_SEL_OUT:    scan_rdata_q <= out_pend_t ? out_data_q : '0;
                dwc_pkg::DWC_SEL_IN:     scan_rdata_q <= in_data_q;
                default:                 scan_rdata_q <= '0;
            endcase
        end
    end

    assign scan_rdata = scan_rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_gate;
        @(posedge mclk) disable iff (!rstn)
        ##1 core_interrupt_gate == !($past(halt_acknowledge) || $past(blk_m));
    endproperty
    a_gate: assert property (p_gate) else $error("interrupt gate wrong"); // [RULE1]

    property p_status_read;
        @(posedge tck) disable iff (!rstn)
        (scan_strobe && !scan_write && scan_sel == dwc_pkg::DWC_SEL_STATUS)
        |=> scan_rdata == {27'h0, $past(status)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong"); // [RULE3]

    property p_out_set;
        @(posedge mclk) disable iff (!rstn)
        (op == dwc_pkg::DWC_OP_WR_OUT && !out_pend_m)
        |=> out_pend_m && out_data_q == $past(cp_req.wdata);
    endproperty
    a_out_set: assert property (p_out_set) else $error("outbound flag not set"); // [RULE16]

    property p_out_clr;
        @(posedge tck) disable iff (!rstn)
        (scan_strobe && !scan_write && scan_sel == dwc_pkg::DWC_SEL_OUT && out_pend_t)
        |=> !out_pend_t;
    endproperty
    a_out_clr: assert property (p_out_clr) else $error("outbound flag not cleared"); // [RULE18]

    property p_in_set;
        @(posedge tck) disable iff (!rstn)
        (scan_strobe && scan_write && scan_sel == dwc_pkg::DWC_SEL_IN && !in_pend_t)
        |=> in_pend_t;
    endproperty
    a_in_set: assert property (p_in_set) else $error("inbound flag not set"); // [RULE19]

    property p_in_clr;
        @(posedge mclk) disable iff (!rstn)
        (op == dwc_pkg::DWC_OP_RD_IN && in_pend_m) |=> !in_pend_m;
    endproperty
    a_in_clr: assert property (p_in_clr) else $error("inbound flag not cleared"); // [RULE21]

    property p_link;
        @(posedge mclk) disable iff (!rstn)
        a_m[1] |=> link_trigger_out == $past(d_m[1]);
    endproperty
    a_link: assert property (p_link) else $error("link latch wrong"); // [RULE10]

    property p_span;
        @(posedge mclk) disable iff (!rstn)
        (a_m[1] && d_m[1] && !wp_cfg[1].cv[`DWC_C_EN]) |=> span_check_out;
    endproperty
    a_span: assert property (p_span) else $error("span lost on disabled unit"); // [RULE12]

    property p_hs_read;
        @(posedge mclk) disable iff (!rstn)
        (op == dwc_pkg::DWC_OP_RD_HS) |=> cp_rdata[31:28] == `DWC_HS_VER
            && cp_rdata[1] == $past(out_pend_m) && cp_rdata[0] == $past(in_pend_m);
    endproperty
    a_hs_read: assert property (p_hs_read) else $error("handshake word wrong"); // [RULE15]

endmodule : dwc_top

`default_nettype wire

/* dwc_map.svh */
// register offsets, field positions, codes and counts of the debug watch/comms block
`ifndef DWC_MAP_SVH
`define DWC_MAP_SVH
// status readback fields
`define DWC_ST_W      5
`define DWC_ST_REQ    1
`define DWC_ST_ACK    0
`define DWC_ST_GATE   2
`define DWC_ST_MREQ   3
`define DWC_ST_CSTATE 4
// coprocessor transfer decode
`define DWC_CP_NUM    4'he
`define DWC_CP_OPC    3'h0
`define DWC_CRN_HS    4'h0
`define DWC_CRN_DATA  4'h1
`define DWC_CRM       4'h0
// handshake control fields
`define DWC_HS_VER_HI 31
`define DWC_HS_VER_LO 28
`define DWC_HS_OUT    1
`define DWC_HS_IN     0
`define DWC_HS_VER    4'h5
// watchpoint control bits
`define DWC_C_CHAIN   6
`define DWC_C_RANGE   7
`define DWC_C_EN      8
// synchroniser depth
`define DWC_SYNC      2
`endif

/* dwc_pkg.sv */
// types shared by the debug watch/comms block
package dwc_pkg;
    typedef struct packed {
        logic [31:0] av;
        logic [31:0] am;
        logic [31:0] dv;
        logic [31:0] dm;
        logic [8:0]  cv;
        logic [7:0]  cm;
    } dwc_wp_cfg_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [5:0]  ctrl;
    } dwc_bus_t;
    typedef struct packed {
        logic        valid;
        logic [3:0]  num;
        logic [2:0]  opc;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic        to_cop;
        logic [31:0] wdata;
    } dwc_cp_req_t;
    typedef enum logic [1:0] {
        DWC_SEL_STATUS = 2'h0,
        DWC_SEL_HS     = 2'h1,
        DWC_SEL_OUT    = 2'h2,
        DWC_SEL_IN     = 2'h3
    } dwc_sel_t;
    typedef enum logic [1:0] {
        DWC_OP_NONE   = 2'h0,
        DWC_OP_RD_HS  = 2'h1,
        DWC_OP_WR_OUT = 2'h2,
        DWC_OP_RD_IN  = 2'h3
    } dwc_op_t;
endpackage : dwc_pkg

/* dwc_dbg_host.sv */
// host debugger model: scan accesses to the block on the test clock
`timescale 1ns/1ps
`default_nettype none
module dwc_dbg_host (
    // test clock and reset
    input  wire logic          tck,
    input  wire logic          rstn,
    // scan access
    output logic               scan_strobe,
    output dwc_pkg::dwc_sel_t  scan_sel,
    output logic               scan_write,
    output logic [31:0]        scan_wdata,
    input  wire logic [31:0]   scan_rdata
);
    ////////////////////////////////////////////////////////////////////////////
    // idle levels at time zero
    initial begin
        scan_strobe = 1'b0;
        scan_sel    = dwc_pkg::DWC_SEL_STATUS;
        scan_write  = 1'b0;
        scan_wdata  = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one access: strobe high for one tck cycle, answer after the taking edge
    task automatic access(input dwc_pkg::dwc_sel_t sel, input logic wr,
                          input logic [31:0] wd, output logic [31:0] rd);
        @(posedge tck);
        scan_strobe <= 1'b1;
        scan_sel    <= sel;
        scan_write  <= wr;   // high writes, low reads
        scan_wdata  <= wd;
        @(posedge tck);
        scan_strobe <= 1'b0;
        scan_wdata  <= ~wd;  // released data shows no stale word
        #1 rd = scan_rdata;  // flags arrive already synchronised
    endtask : access

    // inbound word only once the processor has collected the earlier one
    task automatic put_word(input logic [31:0] w);
        logic [31:0] hs;
        hs = 32'h1;
        for (int n = 0; n < 40 && hs[0] !== 1'b0; n++) begin
            access(dwc_pkg::DWC_SEL_HS, 1'b0, 32'h0, hs);
        end
        if (hs[0] === 1'b0) begin
            access(dwc_pkg::DWC_SEL_IN, 1'b1, w, hs);
        end
    endtask : put_word
endmodule : dwc_dbg_host
`default_nettype wire

/* dwc_top_tb.sv */
// self-checking bench for the debug watch/comms block
`include "dwc_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dwc_top_tb;
    logic                  mclk, rstn, tck;
    logic                  halt_request, halt_acknowledge, interrupt_block_bit;
    logic                  core_memory_request_n, compressed_state_flag;
    logic                  core_interrupt_gate, breakpoint, link_trigger_out;
    logic                  span_check_out, cp_accept, scan_strobe, scan_write;
    dwc_pkg::dwc_wp_cfg_t  wp_cfg [2];
    dwc_pkg::dwc_bus_t     bus;
    dwc_pkg::dwc_cp_req_t  cp_req;
    dwc_pkg::dwc_sel_t     scan_sel;
    logic [31:0]           cp_rdata, scan_rdata, scan_wdata;
    int                    err_total, n_compared, cycles;

    dwc_top #(.SYNC(2)) u_dwc_top (.mclk, .rstn, .tck, .halt_request, .halt_acknowledge,
        .interrupt_block_bit, .core_memory_request_n, .compressed_state_flag,
        .core_interrupt_gate, .wp_cfg, .bus, .breakpoint, .link_trigger_out,
        .span_check_out, .cp_req, .cp_accept, .cp_rdata, .scan_strobe, .scan_sel,
        .scan_write, .scan_wdata, .scan_rdata);
    dwc_dbg_host u_dwc_dbg_host (.tck, .rstn, .scan_strobe, .scan_sel, .scan_write,
        .scan_wdata, .scan_rdata);

    ////////////////////////////////////////////////////////////////////////////
    // clocks: test clock offset so the two never line up
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        tck = 1'b0;
        #1.7;
        forever #3 tck = ~tck;
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor transfer: valid for one mclk, read data one edge later
    task automatic cp_op(input logic [3:0] crn, input logic [3:0] crm, input logic dir,
                         input logic [31:0] wd, output logic acc, output logic [31:0] rd);
        @(posedge mclk);
        cp_req <= '{valid: 1'b1, num: 4'he, opc: 3'h0, crn: crn, crm: crm, to_cop: dir,
                    wdata: wd};
        #1 acc = cp_accept;
        @(posedge mclk);
        cp_req.valid <= 1'b0;
        #1 rd = cp_rdata;
    endtask : cp_op

    // poll a handshake flag from the processor, bounded
    task automatic cp_wait(input int idx, input logic val);
        logic        acc;
        logic [31:0] hs;
        hs = 32'h0;
        for (int n = 0; n < 40; n++) begin
            cp_op(4'h0, 4'h0, 1'b0, 32'h0, acc, hs);
            if (hs[idx] === val) break;
        end
        `CHK(hs[idx], val)
    endtask : cp_wait

    // poll a handshake flag from the debugger, bounded
    task automatic sc_wait(input int idx, input logic val);
        logic [31:0] hs;
        hs = 32'h0;
        for (int n = 0; n < 40; n++) begin
            u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_HS, 1'b0, 32'h0, hs);
            if (hs[idx] === val) break;
        end
        `CHK(hs[idx], val)
    endtask : sc_wait

    task automatic st_chk(input logic [4:0] exp);
        logic [31:0] rd;
        u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_STATUS, 1'b0, 32'h0, rd);
        `CHK(rd, {27'h0, exp})
    endtask : st_chk

    // hold a bus cycle long enough for the latch and the registered outputs
    task automatic bus_step(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, data: d, ctrl: 6'h0};
        repeat (3) @(posedge mclk);
        #1;
    endtask : bus_step

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic        acc;
        logic [31:0] rd;
        `CHK(core_interrupt_gate, 1'b1)
        `CHK({breakpoint, link_trigger_out, span_check_out}, 3'h0)
        cp_op(4'h0, 4'h0, 1'b0, 32'h0, acc, rd);
        `CHK(acc, 1'b1)
        `CHK({rd[31:28], rd[1:0]}, {`DWC_HS_VER, 2'b00})
        u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_HS, 1'b1, 32'hffff_ffff, rd);
        u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_HS, 1'b0, 32'h0, rd);
        `CHK({rd[31:28], rd[1:0]}, {`DWC_HS_VER, 2'b00})
        $display("test reset done");
    endtask : t_reset

    task automatic t_out();
        logic        acc;
        logic [31:0] rd;
        cp_wait(1, 1'b0);
        cp_op(4'h1, 4'h0, 1'b1, 32'hcafe_0123, acc, rd);
        `CHK(acc, 1'b1)
        cp_wait(1, 1'b1);
        sc_wait(1, 1'b1);
        u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_OUT, 1'b0, 32'h0, rd);
        `CHK(rd, 32'hcafe_0123)
        sc_wait(1, 1'b0);
        cp_wait(1, 1'b0);
        $display("test outbound done");
    endtask : t_out

    task automatic t_in();
        logic        acc;
        logic [31:0] rd;
        u_dwc_dbg_host.put_word(32'h5a5a_0f0f);
        sc_wait(0, 1'b1);
        u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_IN, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h5a5a_0f0f)
        cp_wait(0, 1'b1);
        cp_op(4'h1, 4'h0, 1'b0, 32'h0, acc, rd);
        `CHK(rd, 32'h5a5a_0f0f)
        cp_op(4'h0, 4'h0, 1'b0, 32'h0, acc, rd);
        `CHK(rd[0], 1'b0)
        sc_wait(0, 1'b0);
        cp_op(4'h0, 4'h1, 1'b0, 32'h0, acc, rd);
        `CHK(acc, 1'b0)
        $display("test inbound done");
    endtask : t_in

    task automatic t_status();
        logic [31:0] rd;
        @(posedge mclk);
        halt_acknowledge      <= 1'b1;
        halt_request          <= 1'b1;
        core_memory_request_n <= 1'b0;
        compressed_state_flag <= 1'b1;
        repeat (10) @(posedge mclk);
        st_chk(5'b10011);
        `CHK(core_interrupt_gate, 1'b0)
        u_dwc_dbg_host.access(dwc_pkg::DWC_SEL_STATUS, 1'b1, 32'hffff_ffff, rd);
        st_chk(5'b10011);
        @(posedge mclk);
        halt_acknowledge      <= 1'b0;
        core_memory_request_n <= 1'b1;
        compressed_state_flag <= 1'b0;
        @(posedge tck);
        interrupt_block_bit <= 1'b1;
        repeat (10) @(posedge mclk);
        st_chk(5'b01010);
        `CHK(core_interrupt_gate, 1'b0)
        @(posedge tck);
        interrupt_block_bit <= 1'b0;
        repeat (10) @(posedge mclk);
        st_chk(5'b01110);
        `CHK(core_interrupt_gate, 1'b1)
        $display("test status done");
    endtask : t_status

    task automatic t_watch();
        @(posedge mclk);
        wp_cfg[1] <= '{av: 32'h200, am: 32'h1, dv: 32'h55, dm: 32'h0, cv: 9'h0, cm: 8'hff};
        wp_cfg[0] <= '{av: 32'h300, am: 32'h0, dv: 32'h0, dm: '1, cv: 9'h140, cm: 8'hbf};
        bus_step(32'h300, 32'h0);
        `CHK(breakpoint, 1'b0)
        bus_step(32'h201, 32'h55);
        `CHK({link_trigger_out, span_check_out, breakpoint}, 3'b110)
        bus_step(32'h300, 32'h0);
        `CHK({link_trigger_out, breakpoint}, 2'b11)
        bus_step(32'h200, 32'h66);
        `CHK({link_trigger_out, span_check_out}, 2'b00)
        bus_step(32'h202, 32'h55);
        `CHK(span_check_out, 1'b0)
        bus_step(32'h300, 32'h0);
        `CHK(breakpoint, 1'b0)
        $display("test watch done");
    endtask : t_watch

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // hang guard well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        err_total             = 0;
        n_compared            = 0;
        cycles                = 0;
        rstn                  = 1'b0;
        halt_request          = 1'b0;
        halt_acknowledge      = 1'b0;
        interrupt_block_bit   = 1'b0;
        core_memory_request_n = 1'b1;
        compressed_state_flag = 1'b0;
        wp_cfg[0]             = '0;
        wp_cfg[1]             = '0;
        wp_cfg[0].av          = '1;  // idle bus must not match
        wp_cfg[1].av          = '1;
        bus                   = '0;
        cp_req                = '0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_out();
        t_in();
        t_status();
        t_watch();
        summarize();
    end
endmodule : dwc_top_tb
`default_nettype wire
